// *** core/clk_ctrl_defines.vh ***
`ifndef CLK_CTRL_DEFINES_VH
`define CLK_CTRL_DEFINES_VH
// ----------------------------------------------------------------
// register byte addresses (apb, one word each)
// ----------------------------------------------------------------
`define ADDR_OSC_CTRL   12'h000
`define ADDR_CLK_DIV    12'h004
`define ADDR_TRIM       12'h008
`define ADDR_STATUS     12'h00c
// ----------------------------------------------------------------
// unlock keys, divider reset value and settle count
// ----------------------------------------------------------------
`define KEY_HI_1        8'h78
`define KEY_HI_2        8'h9a
`define KEY_LO_1        8'h46
`define KEY_LO_2        8'h57
`define CLK_DIV_RESET   16'h0100
`define SETTLE_CYCLES   4'ha
// ----------------------------------------------------------------
// source encoding
// ----------------------------------------------------------------
`define SRC_FRC         3'h0
`define SRC_FRC_PLL     3'h1
`define SRC_PRI         3'h2
`define SRC_PRI_PLL     3'h3
`define SRC_SEC         3'h4
`define SRC_LOW_POWER_RC_OSC        3'h5
`define SRC_FRC_DIV     3'h7
`endif

// *** core/clock_divider_and_switch_ctrl.v ***
// Implementation choices: the register offsets and the APB register port.
`include "clk_ctrl_defines.vh"
`default_nettype none
module clock_divider_and_switch_ctrl (
  input  wire        clk,
  input  wire        rstn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        irq_event,
  input  wire        switch_disable_cfg,
  input  wire        switch_monitor_cfg,
  input  wire        low_power_rc_osc_needed,
  input  wire [2:0]  initial_source_cfg,
  input  wire [1:0]  primary_submode_cfg,
  input  wire [4:0]  osc_ready_raw,
  input  wire [4:0]  new_clk_edge_raw,
  input  wire        pll_lock_raw,
  input  wire        clock_fail_raw,
  output reg  [4:0]  osc_enable,
  output reg  [4:0]  clk_select,
  output reg  [7:0]  cpu_periph_ratio,
  output reg  [8:0]  fast_rc_postscale_div,
  output reg  [3:0]  usb_sys_clk_div,
  output reg  [5:0]  fast_rc_trim_value,
  output reg  [1:0]  primary_submode
);
  // oscillator one-hot index: 0 frc, 1 primary, 2 secondary, 3 low_power_rc_osc, 4 pll
  localparam ST_IDLE   = 2'h0;
  localparam ST_WAIT   = 2'h1;
  localparam ST_SETTLE = 2'h2;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // one-hot oscillator set needed by a source code
  function [4:0] osc_set;
    input [2:0] src;
    begin
      case (src)
        `SRC_FRC_PLL: osc_set = 5'h11;
        `SRC_PRI:     osc_set = 5'h02;
        `SRC_PRI_PLL: osc_set = 5'h12;
        `SRC_SEC:     osc_set = 5'h04;
        `SRC_LOW_POWER_RC_OSC:    osc_set = 5'h08;
        default:      osc_set = 5'h01;
      endcase
    end
  endfunction

  // oscillator whose clock drives the system when a source is chosen
  function [4:0] clk_of;
    input [2:0] src;
    begin
      case (src)
        `SRC_FRC_PLL, `SRC_PRI_PLL: clk_of = 5'h10;
        `SRC_PRI:  clk_of = 5'h02;
        `SRC_SEC:  clk_of = 5'h04;
        `SRC_LOW_POWER_RC_OSC: clk_of = 5'h08;
        default:   clk_of = 5'h01;
      endcase
    end
  endfunction

  function uses_pll;
    input [2:0] src;
    begin
      uses_pll = (src == `SRC_FRC_PLL) || (src == `SRC_PRI_PLL);
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers: three flops, change counts when 2nd and 3rd agree
  // ----------------------------------------------------------------
  reg [11:0] s1_q, s2_q, s3_q;
  reg [11:0] sync_q;
  wire [11:0] raw_in = {clock_fail_raw, pll_lock_raw,
                        new_clk_edge_raw, osc_ready_raw};
  // filter on stages 2 and 3 only; stage 1 feeds stage 2 alone
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q   <= 12'h000;
      s2_q   <= 12'h000;
      s3_q   <= 12'h000;
      sync_q <= 12'h000;
    end else begin
      s1_q   <= raw_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      sync_q <= (s2_q & s3_q) | (sync_q & (s2_q | s3_q));
    end
  end
  wire [4:0] osc_ready  = sync_q[4:0];
  wire [4:0] edge_lvl   = sync_q[9:5];
  wire       pll_lock_s = sync_q[10];
  wire       fail_s     = sync_q[11];
  reg  [4:0] edge_prev_q;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg        roi_q, ratio_apply_enable_q;
  reg [2:0]  doze_q, fast_rc_postscale_sel_q, current_source_sel_q, next_source_sel_q;
  reg [1:0]  usb_sys_clk_postscale_q;
  reg [5:0]  tun_q;
  reg        freeze_q, sec_en_q, switch_request_q, lock_q, cf_q;
  reg [1:0]  key_hi_q, key_lo_q;
  reg [1:0]  st_q;
  reg [3:0]  cnt_q;
  reg        cap_q;

  wire acc    = psel && penable;
  wire wr     = acc && pwrite;
  wire wr_osc = wr && (paddr == `ADDR_OSC_CTRL);
  wire wr_hi  = wr_osc && pstrb[1];
  wire wr_lo  = wr_osc && pstrb[0];
  wire [7:0] hi_b = pwdata[15:8];
  wire [7:0] lo_b = pwdata[7:0];
  // freeze only bites with the fail-safe monitor on
  wire sel_frozen = switch_monitor_cfg && freeze_q;
  // with switching off the current field shows the power-on source
  wire [2:0] cur_src = switch_disable_cfg ? initial_source_cfg :
                       current_source_sel_q;
  wire [4:0] tgt_clk = clk_of(next_source_sel_q);
  wire       tgt_rdy = ((osc_set(next_source_sel_q) & ~osc_ready) == 5'h00) &&
                       (!uses_pll(next_source_sel_q) || pll_lock_s);
  wire       new_edge = |(tgt_clk & edge_lvl & ~edge_prev_q);

  // ----------------------------------------------------------------
  // apb writes, unlock keys, switch sequencer
  // ----------------------------------------------------------------
  // the core is never stalled: the sequencer runs beside the bus
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      roi_q <= 1'b0; ratio_apply_enable_q <= 1'b0; doze_q <= 3'h0;
      fast_rc_postscale_sel_q <= 3'h1; usb_sys_clk_postscale_q <= 2'h0; tun_q <= 6'h00;
      current_source_sel_q <= 3'h0; next_source_sel_q <= 3'h0; cap_q <= 1'b1;
      freeze_q <= 1'b0; sec_en_q <= 1'b0; switch_request_q <= 1'b0;
      lock_q <= 1'b0; cf_q <= 1'b0;
      key_hi_q <= 2'h0; key_lo_q <= 2'h0;
      st_q <= ST_IDLE; cnt_q <= 4'h0; edge_prev_q <= 5'h00;
    end else begin
      edge_prev_q <= edge_lvl;
      // power-on source caught once after reset release
      if (cap_q) begin
        cap_q  <= 1'b0;
        current_source_sel_q <= initial_source_cfg;
        next_source_sel_q <= initial_source_cfg;
      end
      if (wr && paddr == `ADDR_CLK_DIV) begin
        if (pstrb[1]) begin
          roi_q <= pwdata[15]; doze_q <= pwdata[14:12];
          ratio_apply_enable_q <= pwdata[11]; fast_rc_postscale_sel_q <= pwdata[10:8];
        end
        if (pstrb[0])
          usb_sys_clk_postscale_q <= pwdata[7:6]; // bits 5-0 dropped
      end
      if (wr && paddr == `ADDR_TRIM && pstrb[0])
        tun_q <= pwdata[5:0];
      // interrupt recovery wins over a write in the same cycle
      if (roi_q && irq_event)
        ratio_apply_enable_q <= 1'b0;
      // high byte unlock: 78h, 9ah, then the data byte
      if (wr_hi) begin
        if (key_hi_q == 2'h2) begin
          if (!sel_frozen && !switch_disable_cfg)
            next_source_sel_q <= hi_b[2:0];
          key_hi_q <= 2'h0;
        end else if (hi_b == `KEY_HI_1)
          key_hi_q <= 2'h1;
        else if (key_hi_q == 2'h1 && hi_b == `KEY_HI_2)
          key_hi_q <= 2'h2;
        else
          key_hi_q <= 2'h0;
      end else if (wr)
        key_hi_q <= 2'h0;
      // low byte unlock: 46h, 57h, then the data byte
      if (wr_lo) begin
        if (key_lo_q == 2'h2) begin
          if (lo_b[7] && switch_monitor_cfg)
            freeze_q <= 1'b1; // set only
          sec_en_q <= lo_b[1];
          if (!lo_b[3])
            cf_q <= 1'b0; // clear only
          if (lo_b[0] && !switch_disable_cfg && !sel_frozen)
            switch_request_q <= 1'b1;
          key_lo_q <= 2'h0;
        end else if (lo_b == `KEY_LO_1)
          key_lo_q <= 2'h1;
        else if (key_lo_q == 2'h1 && lo_b == `KEY_LO_2)
          key_lo_q <= 2'h2;
        else
          key_lo_q <= 2'h0;
      end else if (wr)
        key_lo_q <= 2'h0;
      // lock follows the pll only in pll modes
      if (st_q == ST_IDLE)
        lock_q <= uses_pll(current_source_sel_q) && pll_lock_s;
      if (fail_s)
        cf_q <= 1'b1; // hardware set wins over clear
      case (st_q)
        ST_IDLE: begin
          if (switch_request_q) begin
            if (next_source_sel_q == current_source_sel_q)
              switch_request_q <= 1'b0;
            else begin
              lock_q <= 1'b0;
              cf_q   <= fail_s;
              st_q   <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          lock_q <= uses_pll(next_source_sel_q) && pll_lock_s;
          if (tgt_rdy) begin
            cnt_q <= 4'h0;
            st_q  <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (new_edge) begin
            if (cnt_q == `SETTLE_CYCLES - 4'h1) begin
              current_source_sel_q  <= next_source_sel_q;
              switch_request_q <= 1'b0;
              st_q    <= ST_IDLE;
            end else
              cnt_q <= cnt_q + 4'h1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
      if (switch_disable_cfg)
        switch_request_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // apb read data and handshake: zero wait states
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h00000000; pready <= 1'b0; pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && !penable) begin
        pslverr <= paddr > `ADDR_STATUS || paddr[1:0] != 2'h0;
        case (paddr)
          `ADDR_OSC_CTRL: prdata <= {17'h0, cur_src, 1'b0, next_source_sel_q,
                                     freeze_q, 1'b0, lock_q, 1'b0, cf_q,
                                     1'b0, sec_en_q, switch_request_q};
          `ADDR_CLK_DIV:  prdata <= {16'h0, roi_q, doze_q, ratio_apply_enable_q,
                                     fast_rc_postscale_sel_q, usb_sys_clk_postscale_q, 6'h00};
          `ADDR_TRIM:     prdata <= {26'h0, tun_q};
          `ADDR_STATUS:   prdata <= {24'h0, 2'h0, st_q, cnt_q};
          default:        prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // clock outputs
  // ----------------------------------------------------------------
  // a switch request moves select only after settling on the new clock, so the glitch-
  // free mux downstream sees a single clean one-hot change
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_enable <= 5'h01; clk_select <= 5'h01;
      cpu_periph_ratio <= 8'h01; fast_rc_postscale_div <= 9'h002;
      usb_sys_clk_div <= 4'h1; fast_rc_trim_value <= 6'h00;
      primary_submode <= 2'h0;
    end else begin
      clk_select <= clk_of(cur_src);
      // old source dropped once current moves, keepers retained
      osc_enable <= osc_set(cur_src) |
                    ((st_q != ST_IDLE) ? osc_set(next_source_sel_q) : 5'h00) |
                    {1'b0, low_power_rc_osc_needed, sec_en_q, 2'b00};
      cpu_periph_ratio <= ratio_apply_enable_q ? (8'h01 << doze_q) : 8'h01;
      fast_rc_postscale_div <= (fast_rc_postscale_sel_q == 3'h7) ? 9'h100 :
                               (9'h001 << fast_rc_postscale_sel_q);
      usb_sys_clk_div <= 4'h1 << usb_sys_clk_postscale_q;
      fast_rc_trim_value <= tun_q;
      primary_submode <= primary_submode_cfg;
    end
  end
endmodule
`default_nettype wire

// *** tb/clk_ctrl_monitor.sv ***
`default_nettype none
module clk_ctrl_monitor (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq_event,
  input wire logic [4:0]  clk_select,
  input wire logic [7:0]  cpu_periph_ratio,
  input wire logic [8:0]  fast_rc_postscale_div,
  input wire logic [3:0]  usb_sys_clk_div,
  input wire logic [5:0]  fast_rc_trim_value
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // --------------------------------------------
  // completed apb writes to divider and trim
  // --------------------------------------------
  sequence div_wr;
    psel && penable && pready && pwrite && paddr == 12'h004;
  endsequence
  sequence trim_wr;
    psel && penable && pready && pwrite && paddr == 12'h008;
  endsequence
  logic [15:0] div_q;
  logic [5:0]  trim_q;
  // keep the written words, since pwdata moves on after the access
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_q  <= 16'h0100;
      trim_q <= 6'h00;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == 12'h004) div_q <= pwdata[15:0];
      if (paddr == 12'h008) trim_q <= pwdata[5:0];
    end
  end
  // --------------------------------------------
  // checks
  // --------------------------------------------
  ratio_apply_a: assert property (div_wr ##0 (pstrb[1] && !irq_event) |=>
    ##[0:1] cpu_periph_ratio == (div_q[11] ? 8'h01 << div_q[14:12] : 8'h01))
    else $error("cpu ratio does not follow divider write");
  rc_postscale_a: assert property (div_wr ##0 pstrb[1] |=>
    ##[0:1] fast_rc_postscale_div ==
    (div_q[10:8] == 3'h7 ? 9'h100 : 9'h001 << div_q[10:8]))
    else $error("rc postscale does not follow divider write");
  usb_div_a: assert property (div_wr ##0 pstrb[0] |=>
    ##[0:1] usb_sys_clk_div == 4'h1 << div_q[7:6])
    else $error("usb divide does not follow divider write");
  trim_out_a: assert property (trim_wr ##0 pstrb[0] |=>
    ##[0:1] fast_rc_trim_value == trim_q)
    else $error("trim output does not follow trim write");
  irq_recover_a: assert property (div_q[15] && irq_event |->
    ##[1:2] cpu_periph_ratio == 8'h01)
    else $error("interrupt did not restore unit ratio");
  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready in first access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  bad_addr_a: assert property (psel && penable && pready &&
    paddr > 12'h00c |-> pslverr)
    else $error("unmapped access not refused");
  sel_onehot_a: assert property ($onehot(clk_select))
    else $error("system clock select not one-hot");
endmodule
bind clock_divider_and_switch_ctrl clk_ctrl_monitor mon_u (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .pslverr(pslverr), .irq_event(irq_event), .clk_select(clk_select),
  .cpu_periph_ratio(cpu_periph_ratio),
  .fast_rc_postscale_div(fast_rc_postscale_div),
  .usb_sys_clk_div(usb_sys_clk_div), .fast_rc_trim_value(fast_rc_trim_value));
`default_nettype wire

// *** tb/clock_divider_and_switch_ctrl_tb_top.sv ***
`default_nettype none
module clock_divider_and_switch_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic        irq_event, sw_dis, pll_lock;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, usb_div;
  logic [2:0]  init_src;
  logic [4:0]  osc_ready, edge_raw, osc_en, clk_sel;
  logic [7:0]  ratio;
  logic [8:0]  rc_div;
  logic [5:0]  trim;
  logic [1:0]  submode;
  integer      n_mismatch = 0, total_checks = 0, seed = 91, i, d, m;
  clock_divider_and_switch_ctrl dut_u (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_event(irq_event), .switch_disable_cfg(sw_dis),
    .switch_monitor_cfg(1'b0), .low_power_rc_osc_needed(1'b0),
    .initial_source_cfg(init_src), .primary_submode_cfg(2'h1),
    .osc_ready_raw(osc_ready), .new_clk_edge_raw(edge_raw),
    .pll_lock_raw(pll_lock), .clock_fail_raw(1'b0), .osc_enable(osc_en),
    .clk_select(clk_sel), .cpu_periph_ratio(ratio),
    .fast_rc_postscale_div(rc_div), .usb_sys_clk_div(usb_div),
    .fast_rc_trim_value(trim), .primary_submode(submode));
  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // oscillator edges toggle every second cycle: a toggle on every cycle
  // never lets two synchroniser stages agree, so no edge would be seen
  logic edge_div = 1'b0;
  always @(posedge clk) begin
    edge_div <= ~edge_div;
    if (edge_div)
      edge_raw <= ~edge_raw;
  end
  // --------------------------------------------
  // shared tasks
  // --------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] dt, input logic [3:0] s);
    integer k;
    k = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= dt;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_mismatch++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [31:0] msk, exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(nm, rd & msk, exp);
  endtask
  // key pair then value, all to the same byte lane
  task automatic unl(input logic hi, input logic [7:0] v);
    apb(1'b1, 12'h000, {4{hi ? 8'h78 : 8'h46}}, hi ? 4'h2 : 4'h1);
    apb(1'b1, 12'h000, {4{hi ? 8'h9a : 8'h57}}, hi ? 4'h2 : 4'h1);
    apb(1'b1, 12'h000, {4{v}}, hi ? 4'h2 : 4'h1);
  endtask
  task automatic do_reset(input logic dis, input logic [2:0] src);
    rstn     <= 1'b0;
    sw_dis   <= dis;
    init_src <= src;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
  endtask
  // --------------------------------------------
  // main sequence
  // --------------------------------------------
  initial begin
    {psel, penable, pwrite, irq_event, pll_lock} = 5'h00;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    pstrb     = 4'h0;
    osc_ready = 5'h01;
    edge_raw  = 5'h00;
    rstn      = 1'b0;
    do_reset(1'b0, 3'h0);
    rdchk("div reset", 12'h004, 32'hffffffff, 32'h0100);
    rdchk("osc reset", 12'h000, 32'h7701, 32'h0);
    chk("submode", submode, 32'h1);
    // usb is never enabled here, so every postscale code is legal
    for (i = 0; i < 12; i++) begin
      d = $random(seed);
      m = d & 32'hffc0;
      apb(1'b1, 12'h004, d, 4'h3);
      rdchk("div", 12'h004, 32'hffffffff, m);
      chk("ratio", ratio, m[11] ? 1 << m[14:12] : 1);
      chk("rc div", rc_div, m[10:8] == 7 ? 256 : 1 << m[10:8]);
      chk("usb div", usb_div, 1 << m[7:6]);
      apb(1'b1, 12'h008, d, 4'h3);
      rdchk("trim", 12'h008, 32'hffffffff, d & 32'h3f);
      chk("trim out", trim, d & 32'h3f);
    end
    for (i = 0; i < 2; i++) begin
      apb(1'b1, 12'h004, i ? 32'h3b00 : 32'hb900, 4'h3);
      irq_event <= 1'b1;
      @(posedge clk);
      irq_event <= 1'b0;
      repeat (3) @(posedge clk);
      chk("irq ratio", ratio, i ? 8 : 1);
      rdchk("irq div", 12'h004, 32'hffff, i ? 32'h3b00 : 32'hb100);
    end
    apb(1'b0, 12'h010, 32'h0, 4'h0);
    chk("unmapped", err, 1);
    apb(1'b1, 12'h000, 32'h02020202, 4'h2);
    rdchk("no key", 12'h000, 32'h0700, 32'h0);
    // plain fast rc to primary, no pll-to-pll hop
    unl(1'b1, 8'h02);
    rdchk("next src", 12'h000, 32'h0700, 32'h0200);
    osc_ready <= 5'h1f;
    unl(1'b0, 8'h01);
    i = 0;
    do begin
      apb(1'b0, 12'h000, 32'h0, 4'h0);
      i++;
    end while (rd[0] !== 1'b0 && i < 100);
    chk("switch done", rd & 32'h7701, 32'h2200);
    repeat (4) @(posedge clk);
    chk("clk sel", clk_sel, 5'h02);
    chk("osc enable", osc_en, 5'h02);
    unl(1'b0, 8'h01);
    rdchk("redundant", 12'h000, 32'h7701, 32'h2200);
    do_reset(1'b1, 3'h5);
    unl(1'b1, 8'h00);
    unl(1'b0, 8'h01);
    rdchk("disabled", 12'h000, 32'h7001, 32'h5000);
    end_sim();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
endmodule
`default_nettype wire
